// *** hdl/arsf_top.sv ***
`timescale 1ns/10ps
// Behaviour
// - Three axes, thirty-two sixteen-bit entries each.
// - Five buffer modes chosen by control field.
// - Watermark, empty, full routed to interrupt pin.
// - Five-bit watermark compared with fill count.
// - Bypass keeps buffer empty, overwrites single slot.
// - Fill-until-full raises watermark at programmed level.
// - Fill-until-full stops accepting when thirty-two stored.
// - Streaming drops oldest set when full.
// - Buffered modes return stored data on reads.
// - Each first-axis low-byte read loads oldest set out.
// - Burst read wraps third-high to first-low.
// - Sub-address: seven register bits, top auto-increment.
module arsf_top
   import arsf_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   // Sample set from the conversion chain, one pulse per output sample rate
   input wire logic sample_valid,
   input wire logic [15:0] sample_x,
   input wire logic [15:0] sample_y,
   input wire logic [15:0] sample_z,
   // Register port from the serial front end
   input wire logic reg_start,
   input wire logic [7:0] reg_sub_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic [6:0] reg_addr_cur,
   output logic data_ready_second_interrupt_pin
);
   // ------------------------------------------------------------
   // Register and state declarations
   // ------------------------------------------------------------
   logic [7:0] buf_ctrl_q; // Mode and watermark level
   logic [7:0] int_route_q; // Interrupt enables
   logic [6:0] addr_q; // Current register address
   logic inc_q; // Auto-increment latched at sub-address
   logic [47:0] out_q; // Axis output registers {z,y,x}
   logic [47:0] live_q; // Last live sample for bypass
   logic [7:0] rdata_q;
   logic irq_q;
   arsf_mode_t mode;
   logic [4:0] wtm_level;
   logic buffered;
   logic flush;
   logic st_in_valid;
   logic st_in_ready;
   logic st_out_valid;
   logic st_out_ready;
   logic [47:0] st_out_data;
   logic [5:0] fill;
   logic load_pend_q; // Popped set arrives in registered read data
   logic empty_flag;
   logic full_flag;
   logic wtm_flag;
   logic rd_addr_x_low;
   logic [2:0] byte_idx;

   assign mode = arsf_mode_t'(buf_ctrl_q[ARSF_MODE_LSB +: 3]);
   assign wtm_level = buf_ctrl_q[ARSF_WTM_LSB +: 5];
   assign buffered = (mode != ARSF_MODE_BYPASS) && (mode != ARSF_MODE_BYPASS_TO_STREAM);
   // Bypass holds the store flushed, so nothing accumulates
   assign flush = !buffered;

   // ------------------------------------------------------------
   // Sample store
   // ------------------------------------------------------------
   // One 48-bit word carries all three axes, so the axes stay aligned
   arsf_store #(
      .WIDTH(ARSF_WIDTH),
      .DEPTH(ARSF_DEPTH),
      .PTR_W(ARSF_PTR_W),
      .CNT_W(ARSF_CNT_W)
   ) u_store (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .flush(flush),
      .in_valid(st_in_valid),
      .in_ready(st_in_ready),
      .in_data({sample_z, sample_y, sample_x}),
      .out_valid(st_out_valid),
      .out_ready(st_out_ready),
      .out_data(st_out_data),
      .count(fill)
   );

   // Writes only while room remains; fill-until-full stops at thirty-two
   assign st_in_valid = sample_valid && buffered
      && !((mode == ARSF_MODE_FIFO) && full_flag);

   // ------------------------------------------------------------
   // Read-side pop control
   // ------------------------------------------------------------
   // Reading the first-axis low byte fetches the next set (a wrapped
   // burst lands here again, so each six-byte pass pops once)
   assign rd_addr_x_low = reg_rd && (addr_q == ARSF_FIRST_AXIS_LOW_BYTE);
   // Streaming drops the oldest set when a new one meets a full store; the
   // full flag comes from the count, so no loop runs through the store's ready
   assign st_out_ready = (buffered && rd_addr_x_low)
      || (sample_valid && full_flag
          && ((mode == ARSF_MODE_STREAM) || (mode == ARSF_MODE_STREAM_TO_FIFO)));

   // Flags; set follows the live fill so nothing is missed
   assign empty_flag = (fill == 6'h00);
   assign full_flag = (fill == ARSF_FULL_COUNT);
   assign wtm_flag = buffered && (fill >= {1'b0, wtm_level});

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   // Control registers; the host returns to bypass to restart collection
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         buf_ctrl_q <= ARSF_BUF_CTRL_RST;
         int_route_q <= ARSF_INT_ROUTE_RST;
      end
      else if (reg_wr)
      begin
         case (addr_q)
            ARSF_BUF_CTRL_ADDR: buf_ctrl_q <= reg_wdata;
            ARSF_INT_ROUTE_ADDR: int_route_q <= reg_wdata;
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Address pointer
   // ------------------------------------------------------------
   // Low seven bits select, top bit enables increment
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         addr_q <= 7'h00;
         inc_q <= 1'b0;
      end
      else if (reg_start)
      begin
         addr_q <= reg_sub_addr[6:0];
         inc_q <= reg_sub_addr[ARSF_SUB_AUTO_INC_BIT];
      end
      else if ((reg_rd || reg_wr) && inc_q)
      begin
         // Burst over the axis bytes wraps back to the first-axis low byte
         if (addr_q == ARSF_THIRD_AXIS_HIGH_BYTE)
         begin
            addr_q <= ARSF_FIRST_AXIS_LOW_BYTE;
         end
         else
         begin
            addr_q <= addr_q + 7'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // Output registers
   // ------------------------------------------------------------
   // Live sample kept for bypass, single slot overwritten each time
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         live_q <= 48'h0;
      end
      else if (sample_valid)
      begin
         live_q <= {sample_z, sample_y, sample_x};
      end
   end

   // Remember that a popped set will be valid next cycle
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         load_pend_q <= 1'b0;
      end
      else
      begin
         load_pend_q <= buffered && rd_addr_x_low && st_out_valid;
      end
   end

   // Buffered modes show the oldest stored set, bypass the live one.
   // The dummy read at the first-axis low byte loads the set; the byte
   // itself reads the old value, which is why the host discards it.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_q <= 48'h0;
      end
      else if (!buffered)
      begin
         out_q <= live_q;
      end
      else if (load_pend_q)
      begin
         out_q <= st_out_data;
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   assign byte_idx = 3'(addr_q - ARSF_FIRST_AXIS_LOW_BYTE);

   // Read mux registered on the read strobe
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_q <= 8'h00;
      end
      else if (reg_rd)
      begin
         if ((addr_q >= ARSF_FIRST_AXIS_LOW_BYTE) && (addr_q <= ARSF_THIRD_AXIS_HIGH_BYTE))
         begin
            rdata_q <= out_q[byte_idx*8 +: 8];
         end
         else
         begin
            case (addr_q)
               ARSF_BUF_CTRL_ADDR: rdata_q <= buf_ctrl_q;
               ARSF_INT_ROUTE_ADDR: rdata_q <= int_route_q;
               ARSF_BUF_SRC_ADDR: rdata_q <= {wtm_flag, full_flag, empty_flag, fill[4:0]};
               default: rdata_q <= 8'h00;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Interrupt pin
   // ------------------------------------------------------------
   // Each condition enabled on its own; level follows the condition
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_q <= 1'b0;
      end
      else
      begin
         irq_q <= (int_route_q[ARSF_IR_WTM_BIT] && wtm_flag)
            || (int_route_q[ARSF_IR_FULL_BIT] && full_flag)
            || (int_route_q[ARSF_IR_EMPTY_BIT] && empty_flag);
      end
   end

   assign reg_rdata = rdata_q;
   assign reg_addr_cur = addr_q;
   assign data_ready_second_interrupt_pin = irq_q;
endmodule // arsf_top

// *** hdl/arsf_pkg.sv ***
package arsf_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [6:0] ARSF_FIRST_AXIS_LOW_BYTE = 7'h28;
   localparam logic [6:0] ARSF_THIRD_AXIS_HIGH_BYTE = 7'h2D;
   localparam logic [6:0] ARSF_BUF_CTRL_ADDR = 7'h2E;
   localparam logic [6:0] ARSF_BUF_SRC_ADDR = 7'h2F;
   localparam logic [6:0] ARSF_INT_ROUTE_ADDR = 7'h22;
   // Sub-address layout
   localparam int ARSF_SUB_AUTO_INC_BIT = 7;
   // Buffer control fields
   localparam int ARSF_MODE_LSB = 5;
   localparam int ARSF_WTM_LSB = 0;
   // Interrupt routing fields
   localparam int ARSF_IR_EMPTY_BIT = 0;
   localparam int ARSF_IR_FULL_BIT = 1;
   localparam int ARSF_IR_WTM_BIT = 2;
   // Buffer source fields
   localparam int ARSF_SRC_WTM_BIT = 7;
   localparam int ARSF_SRC_FULL_BIT = 6;
   localparam int ARSF_SRC_EMPTY_BIT = 5;
   // Reset values
   localparam logic [7:0] ARSF_BUF_CTRL_RST = 8'h00;
   localparam logic [7:0] ARSF_INT_ROUTE_RST = 8'h00;
   // Geometry
   localparam int ARSF_DEPTH = 32;
   localparam int ARSF_WIDTH = 48;
   localparam int ARSF_PTR_W = 5;
   localparam int ARSF_CNT_W = 6;
   localparam logic [5:0] ARSF_FULL_COUNT = 6'h20;
   // Buffer modes
   typedef enum logic [2:0]
   {
      ARSF_MODE_BYPASS = 3'b000,
      ARSF_MODE_FIFO = 3'b001,
      ARSF_MODE_STREAM = 3'b010,
      ARSF_MODE_STREAM_TO_FIFO = 3'b011,
      ARSF_MODE_BYPASS_TO_STREAM = 3'b100
   } arsf_mode_t;
endpackage

// *** hdl/arsf_store.sv ***
`timescale 1ns/10ps
// Sample store: 48-bit sets, registered read data, valid/ready on both sides
module arsf_store #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 32,
   parameter int PTR_W = 5,
   parameter int CNT_W = 6
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [CNT_W-1:0] count
);
   // ------------------------------------------------------------
   // Storage and pointers
   // ------------------------------------------------------------
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wr_q;
   logic [PTR_W-1:0] rd_q;
   logic [CNT_W-1:0] cnt_q;
   logic push;
   logic pop;

   // A pop in the same cycle frees a slot, so a full store may still take a word
   assign in_ready = (cnt_q != CNT_W'(DEPTH)) || out_ready;
   assign out_valid = (cnt_q != '0);
   assign push = in_valid & in_ready;
   assign pop = out_ready & out_valid;
   assign count = cnt_q;

   // Memory write, no reset so it maps to RAM
   always_ff @(posedge ref_clk)
   begin
      if (push)
      begin
         mem_q[wr_q] <= in_data;
      end
   end

   // Registered read of the head entry as it is popped
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_data <= '0;
      end
      else if (pop)
      begin
         out_data <= mem_q[rd_q];
      end
   end

   // Pointers and count; flush empties the store
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else if (flush)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= wr_q + PTR_W'(1);
         end
         if (pop)
         begin
            rd_q <= rd_q + PTR_W'(1);
         end
         if (push && !pop)
         begin
            cnt_q <= cnt_q + CNT_W'(1);
         end
         else if (pop && !push)
         begin
            cnt_q <= cnt_q - CNT_W'(1);
         end
      end
   end
endmodule // arsf_store

// *** bench/arsf_checker_sva.sv ***
`timescale 1ns/10ps
// Watches the register port and the interrupt pin of the sample buffer
module arsf_checker_sva
   import arsf_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic sample_valid,
   input wire logic reg_start,
   input wire logic [7:0] reg_sub_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [6:0] reg_addr_cur,
   input wire logic data_ready_second_interrupt_pin
);
   // ----
   // Shadow state
   // ----
   logic inc_q; // Auto-increment bit seen at start
   logic [6:0] addr_q; // Address seen at start
   logic [2:0] route_q; // Copy of the routing enables
   logic [2:0] mode_q; // Copy of the buffer mode
   logic [5:0] ev_q; // Recent events that may move the pin
   wire irq = data_ready_second_interrupt_pin;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   // Track the sub-address and the writes to control and routing
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         inc_q <= 1'b0;
         addr_q <= 7'h00;
         route_q <= 3'h0;
         mode_q <= 3'h0;
      end
      else if (reg_start)
      begin
         inc_q <= reg_sub_addr[ARSF_SUB_AUTO_INC_BIT];
         addr_q <= reg_sub_addr[6:0];
      end
      else if (reg_wr && reg_addr_cur == ARSF_INT_ROUTE_ADDR)
      begin
         route_q <= reg_wdata[2:0];
      end
      else if (reg_wr && reg_addr_cur == ARSF_BUF_CTRL_ADDR)
      begin
         mode_q <= reg_wdata[7:5];
      end
   end
   // Pops land late, so the pin may move a few cycles after its cause
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ev_q <= 6'h00;
      end
      else
      begin
         ev_q <= {ev_q[4:0], sample_valid | reg_rd | reg_wr};
      end
   end
   property p_addr_load;
      reg_start |=> reg_addr_cur == addr_q;
   endproperty
   a_addr_load: assert property (p_addr_load) else $error("address not loaded");
   property p_auto_inc;
      (reg_rd || reg_wr) && inc_q && reg_addr_cur != ARSF_THIRD_AXIS_HIGH_BYTE
         |=> reg_addr_cur == $past(reg_addr_cur) + 7'h01;
   endproperty
   a_auto_inc: assert property (p_auto_inc) else $error("no increment");
   property p_wrap;
      reg_rd && inc_q && reg_addr_cur == ARSF_THIRD_AXIS_HIGH_BYTE
         |=> reg_addr_cur == ARSF_FIRST_AXIS_LOW_BYTE;
   endproperty
   a_wrap: assert property (p_wrap) else $error("burst did not wrap");
   property p_hold_addr;
      !reg_start && !(inc_q && (reg_rd || reg_wr)) |=> $stable(reg_addr_cur);
   endproperty
   a_hold_addr: assert property (p_hold_addr) else $error("address moved");
   property p_irq_cause;
      $changed(irq) |-> ev_q != 6'h00;
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("pin moved alone");
   property p_irq_masked;
      (route_q == 3'h0) [*3] |-> !irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("masked pin high");
   property p_byp_on;
      (mode_q == 3'h0 && route_q[0]) [*3] |-> irq;
   endproperty
   a_byp_on: assert property (p_byp_on) else $error("bypass not empty");
   property p_byp_off;
      (mode_q == 3'h0 && !route_q[0]) [*3] |-> !irq;
   endproperty
   a_byp_off: assert property (p_byp_off) else $error("bypass event");
   property p_src_byp;
      reg_rd && reg_addr_cur == ARSF_BUF_SRC_ADDR && mode_q == 3'h0
         |=> reg_rdata[7:5] == 3'b001;
   endproperty
   a_src_byp: assert property (p_src_byp) else $error("bypass flags wrong");
   c_wrap: cover property (p_wrap);
   c_irq_rise: cover property ($rose(irq));
   c_src_fifo: cover property (reg_rd && reg_addr_cur == ARSF_BUF_SRC_ADDR && mode_q == 3'h1);
endmodule // arsf_checker_sva

// *** bench/arsf_host_model.sv ***
`timescale 1ns/10ps
// Host side of the register port: start, one-byte read, one-byte write
module arsf_host_model
(
   input wire logic ref_clk,
   input wire logic [7:0] reg_rdata,
   output logic reg_start,
   output logic [7:0] reg_sub_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic reg_rd
);
   int gap = 0; // Idle cycles before each start, for a slow host
   // Idle levels at time zero
   initial
   begin
      reg_start = 1'b0;
      reg_sub_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end
   // Bit 7 of the sub-address asks for auto-increment
   task automatic start(input logic [7:0] sub);
      repeat (gap + 1) @(posedge ref_clk);
      reg_start <= 1'b1;
      reg_sub_addr <= sub;
      @(posedge ref_clk);
      reg_start <= 1'b0;
      reg_sub_addr <= ~sub; // Stale value must not be relied on
   endtask
   // Read data holds until the next read, so it is taken a cycle late
   task automatic rd1(output logic [7:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      #1 d = reg_rdata;
   endtask
   // One write at the current address
   task automatic wr1(input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask
endmodule // arsf_host_model

// *** bench/testbench.sv ***
`timescale 1ns/10ps
// Self-checking bench for the sample buffer
module testbench;
   import arsf_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic sample_valid = 1'b0;
   logic [15:0] sample_x = 16'h0000;
   logic [15:0] sample_y = 16'h0000;
   logic [15:0] sample_z = 16'h0000;
   logic reg_start, reg_wr, reg_rd, irq;
   logic [7:0] reg_sub_addr, reg_wdata, reg_rdata, d;
   logic [6:0] reg_addr_cur;
   int err_count = 0;
   int n_tests = 0;
   int k = 0; // Index of the next sample set
   always #4 ref_clk = ~ref_clk;
   arsf_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .sample_valid(sample_valid),
      .sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z), .reg_start(reg_start),
      .reg_sub_addr(reg_sub_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_addr_cur(reg_addr_cur), .data_ready_second_interrupt_pin(irq));
   arsf_host_model host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_start(reg_start),
      .reg_sub_addr(reg_sub_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));
   // Sample set j packed as z, y, x
   function automatic logic [47:0] set_of(input int j);
      return {16'h3300 + 16'(j), 16'h2200 + 16'(j), 16'h1100 + 16'(j)};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] sub, input logic [7:0] exp);
      host.start(sub);
      host.rd1(d);
      chk(d, exp);
   endtask
   task automatic wr(input logic [7:0] sub, input logic [7:0] v);
      host.start(sub);
      host.wr1(v);
   endtask
   task automatic push(input int n);
      repeat (n)
      begin
         @(posedge ref_clk);
         sample_valid <= 1'b1;
         {sample_z, sample_y, sample_x} <= set_of(k);
         k++;
         @(posedge ref_clk);
         sample_valid <= 1'b0;
      end
   endtask
   // Burst y and z, then x high, then x low which pops the next set
   task automatic rdset(input int j);
      logic [47:0] e;
      e = set_of(j);
      host.start(8'hAA);
      for (int b = 2; b < 6; b++)
      begin
         host.rd1(d);
         chk(d, e[8*b+:8]);
      end
      chk({1'b0, reg_addr_cur}, 8'h28);
      rchk(8'h29, e[15:8]);
      rchk(8'h28, e[7:0]);
   endtask
   task automatic wait_chk_irq(input logic exp);
      repeat (3) @(posedge ref_clk);
      #1 chk({7'h00, irq}, {7'h00, exp});
   endtask
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
      begin
         $display("Finished cleanly");
      end
      else
      begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Cut a hang short; the whole run needs well under this
   initial
   begin
      repeat (40000) @(posedge ref_clk);
      err_count++;
      $display("BAD %0t watchdog expired", $time);
      print_verdict();
   end
   // Main sequence
   initial
   begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      rchk(8'h2E, ARSF_BUF_CTRL_RST);
      rchk(8'h22, ARSF_INT_ROUTE_RST);
      rchk(8'h2F, 8'h20);
      rchk(8'h10, 8'h00);
      for (int m = 0; m < 5; m++)
      begin
         wr(8'h2E, {3'(m), 5'h07});
         rchk(8'h2E, {3'(m), 5'h07});
      end
      wr(8'h2E, 8'h00);
      $display("test registers done");
      push(2);
      rchk(8'h2A, 8'h01);
      wr(8'h22, 8'h01);
      wait_chk_irq(1'b1);
      $display("test bypass done");
      k = 0;
      wr(8'h22, 8'h04);
      wr(8'h2E, 8'h24);
      push(3);
      wait_chk_irq(1'b0);
      push(1);
      wait_chk_irq(1'b1);
      push(30);
      rchk(8'h2F, 8'hC0);
      rchk(8'h28, 8'h01);
      for (int j = 0; j < 32; j++)
      begin
         rdset(j);
      end
      rchk(8'h2F, 8'h20);
      wait_chk_irq(1'b0);
      $display("test fill until full done");
      wr(8'h2E, 8'h00);
      host.gap = 3;
      k = 0;
      wr(8'h2E, 8'h44);
      push(35);
      rchk(8'h2F, 8'hC0);
      host.start(8'h28);
      host.rd1(d);
      rdset(3);
      wr(8'h2E, 8'h00);
      rchk(8'h2F, 8'h20);
      $display("test streaming done");
      print_verdict();
   end
endmodule // testbench
bind arsf_top arsf_checker_sva u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
   .sample_valid(sample_valid), .reg_start(reg_start), .reg_sub_addr(reg_sub_addr),
   .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .reg_addr_cur(reg_addr_cur),
   .data_ready_second_interrupt_pin(data_ready_second_interrupt_pin));
